// [common/gcc_pkg.sv]
// Package of constants and types for the gated counter channel
package gcc_pkg;
  // ********************
  // Register map
  // ********************
  localparam logic [7:0] GCC_CTRL_OFS = 8'h00;
  localparam logic [7:0] GCC_LOAD_OFS = 8'h04;
  localparam logic [7:0] GCC_END_OFS = 8'h08;
  localparam logic [7:0] GCC_CMPV_OFS = 8'h0c;
  localparam logic [7:0] GCC_PDUR_OFS = 8'h10;
  localparam logic [7:0] GCC_HYST_OFS = 8'h14;
  localparam logic [7:0] GCC_CNT_OFS = 8'h18;
  localparam logic [7:0] GCC_LATCH_OFS = 8'h1c;
  localparam logic [7:0] GCC_STAT_OFS = 8'h20;
  // ********************
  // Control word fields
  // ********************
  localparam int GCC_C_SWG = 0;
  localparam int GCC_C_MODE = 1;
  localparam int GCC_C_DIR = 2;
  localparam int GCC_C_ABORT = 4;
  localparam int GCC_C_HWEN = 5;
  localparam int GCC_C_OMODE = 6;
  localparam int GCC_C_DO = 8;
  localparam int GCC_C_DSW = 9;
  localparam int GCC_C_EVEN = 10;
  localparam int GCC_CTRL_W = 11;
  localparam logic [10:0] GCC_CTRL_RST = 11'h000;
  // Status word fields
  localparam int GCC_S_CMP = 0;
  localparam int GCC_S_DO = 1;
  localparam int GCC_S_GATE = 2;
  localparam int GCC_S_AUTO = 3;
  // ********************
  // Numeric range and timing
  // ********************
  localparam logic [31:0] GCC_MAX = 32'h7fffffff;
  localparam logic [31:0] GCC_MIN = 32'h80000000;
  localparam int GCC_CLK_NS = 4;
  localparam int GCC_MS_NS = 1000000;
  localparam int GCC_MS_CYC = GCC_MS_NS / GCC_CLK_NS;
  localparam int GCC_PDUR_STEP_MS = 2;
  localparam logic [7:0] GCC_HYST_MIN = 8'h01;
  // ********************
  // Modes
  // ********************
  typedef enum logic {GCC_ONCE, GCC_PERIOD} gcc_mode_t;
  typedef enum logic [1:0] {GCC_DNONE, GCC_DFWD, GCC_DBWD, GCC_DRSV}
    gcc_dir_t;
  typedef enum logic [1:0] {GCC_ONONE, GCC_OGE, GCC_OLE, GCC_OPULSE}
    gcc_omode_t;
endpackage

// [dv/gcc_channel_props.sv]
// Port checker for the gated counter channel
module gcc_channel_props
  import gcc_pkg::*;
#(
  parameter int MS_CYC = gcc_pkg::GCC_MS_CYC
) (
  input wire logic clk_i, // Clock
  input wire logic arst_n_i, // Reset
  input wire logic psel_i, // APB select
  input wire logic penable_i, // APB enable
  input wire logic pwrite_i, // APB write
  input wire logic [7:0] paddr_i, // APB address
  input wire logic [31:0] pwdata_i, // APB write data
  input wire logic [31:0] prdata_o, // APB read data
  input wire logic pready_o, // APB ready
  input wire logic pslverr_o, // APB error
  input wire logic cnt_up_i, // Up pulse
  input wire logic cnt_dn_i, // Down pulse
  input wire logic hw_gate_i, // Gate pin
  input wire logic latch_i, // Latch pin
  input wire logic dout_o, // Channel output
  input wire logic wrap_evt_o // Event pulse
);
  logic [10:0] ctl_q;
  logic [7:0] pd_q;
  logic [7:0] pdl_q;
  int hi_q;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  // Shadows; duration frozen while output high, as a new one waits
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctl_q <= GCC_CTRL_RST;
      pd_q <= 8'h00;
      pdl_q <= 8'h00;
      hi_q <= 0;
    end else begin
      if (psel_i && penable_i && pwrite_i && paddr_i == GCC_CTRL_OFS) begin
        ctl_q <= pwdata_i[10:0];
      end
      if (psel_i && penable_i && pwrite_i && paddr_i == GCC_PDUR_OFS) begin
        pd_q <= pwdata_i[7:0];
      end
      if (!dout_o) begin
        pdl_q <= pd_q;
      end
      hi_q <= dout_o ? hi_q + 1 : 0;
    end
  end
  // ********************
  // Sequences and assertions
  // ********************
  sequence s_acc;
    psel_i && penable_i;
  endsequence
  sequence s_bad;
    s_acc ##0 (paddr_i > 8'h20 || paddr_i[1:0] != 2'b00);
  endsequence
  sequence s_quiet;
    !(cnt_up_i || cnt_dn_i) [*3];
  endsequence
  sequence s_pend;
    $fell(dout_o) && ctl_q[7:6] == 2'b11 && ctl_q[8] && $stable(ctl_q)
      && pdl_q != 8'h00;
  endsequence
  AST_READY: assert property (s_acc |-> pready_o)
    else $error("Ready low in access phase");
  AST_ERR_BAD: assert property (s_bad |-> pslverr_o)
    else $error("No error on unmapped access");
  AST_ERR_GOOD: assert property (s_acc ##0 paddr_i <= 8'h20
    && paddr_i[1:0] == 2'b00 |-> !pslverr_o)
    else $error("Error on mapped access");
  AST_ERR_PHASE: assert property (pslverr_o |-> s_acc)
    else $error("Error outside access phase");
  AST_RD_BAD: assert property (s_bad ##0 !pwrite_i |-> prdata_o == '0)
    else $error("Unmapped read not zero");
  AST_EVT_QUIET: assert property (s_quiet |=> !wrap_evt_o)
    else $error("Event without count pulse");
  AST_EVT_EN: assert property (wrap_evt_o |-> ctl_q[10] || $past(ctl_q[10]))
    else $error("Event while disabled");
  AST_PLAIN: assert property (ctl_q[7:6] == 2'b00 && $stable(ctl_q)
    |-> dout_o == ctl_q[9])
    else $error("Plain output wrong");
  AST_PULSE_LEN: assert property (s_pend
    |-> hi_q == 2 * MS_CYC * int'(pdl_q))
    else $error("Pulse length wrong");
endmodule

bind gcc_channel gcc_channel_props #(.MS_CYC(MS_CYC)) gcc_channel_props_inst (
  .clk_i(clk_i), .arst_n_i(arst_n_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .cnt_up_i(cnt_up_i), .cnt_dn_i(cnt_dn_i),
  .hw_gate_i(hw_gate_i), .latch_i(latch_i), .dout_o(dout_o),
  .wrap_evt_o(wrap_evt_o));

// [dv/gcc_channel_tb.sv]
// Self-checking bench for the gated counter channel
module gcc_channel_tb;
  import gcc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, arst_n_i, psel_i, penable_i, pwrite_i, err;
  logic [7:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, d;
  logic pready_o, pslverr_o, cnt_up_i, cnt_dn_i, hw_gate_i, latch_i;
  logic dout_o, wrap_evt_o;
  int fail_count = 0;
  int checked = 0;
  int evt_n = 0;
  int hi_n = 0;
  int e0, h0;
  gcc_channel #(.HAS_HW_GATE(1'b1), .MS_CYC(10)) gcc_channel_inst (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .cnt_up_i(cnt_up_i), .cnt_dn_i(cnt_dn_i),
    .hw_gate_i(hw_gate_i), .latch_i(latch_i), .dout_o(dout_o),
    .wrap_evt_o(wrap_evt_o));
  gcc_enc_model gcc_enc_model_inst (.clk_i(clk_i), .cnt_up_o(cnt_up_i),
    .cnt_dn_o(cnt_dn_i), .hw_gate_o(hw_gate_i), .latch_o(latch_i));
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // Event and output-high counters
  always @(posedge clk_i) begin
    if (wrap_evt_o === 1'b1) evt_n <= evt_n + 1;
    if (dout_o === 1'b1) hi_n <= hi_n + 1;
  end
  // ********************
  // Bus and compare tasks
  // ********************
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Idle cycle at the end so psel is never set twice in one step
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] v);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= v;
    @(posedge clk_i);
    penable_i <= 1'b1;
    @(posedge clk_i);
    while (pready_o !== 1'b1) @(posedge clk_i);
    d = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    apb(1'b1, a, v);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m,
    input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(d & m, e);
  endtask
  task automatic cfg(input logic [31:0] l, input logic [31:0] e,
    input logic [31:0] c);
    wr(GCC_CTRL_OFS, 32'h0);
    wr(GCC_LOAD_OFS, l);
    wr(GCC_END_OFS, e);
    wr(GCC_CTRL_OFS, c);
    e0 = evt_n;
  endtask
  task automatic wrap_up;
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Hang guard, well beyond the few hundred cycles of the run
  initial begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    wrap_up;
  end
  // ********************
  // Scenarios
  // ********************
  initial begin
    arst_n_i = 1'b0;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 8'h00;
    pwdata_i = 32'h0;
    repeat (2) @(posedge clk_i);
    arst_n_i <= 1'b1;
    @(posedge clk_i);
    rdc(GCC_CNT_OFS, '1, 32'h0);
    apb(1'b0, 8'h24, 32'h0);
    chk({31'h0, err}, 32'h1);
    // Once backward: reload, auto close, restart on gate rise
    cfg(32'ha, 32'h5, 32'h419);
    gcc_enc_model_inst.step(1'b0, 4, 1);
    rdc(GCC_CNT_OFS, '1, 32'h6);
    gcc_enc_model_inst.step(1'b0, 1, 3);
    rdc(GCC_CNT_OFS, '1, 32'ha);
    rdc(GCC_STAT_OFS, 32'hc, 32'h8);
    gcc_enc_model_inst.step(1'b0, 1, 1);
    rdc(GCC_CNT_OFS, '1, 32'ha);
    wr(GCC_CTRL_OFS, 32'h418);
    wr(GCC_CTRL_OFS, 32'h419);
    gcc_enc_model_inst.step(1'b0, 1, 1);
    rdc(GCC_CNT_OFS, '1, 32'h9);
    // Periodic forward and backward, then full-range wrap
    cfg(32'h0, 32'h4, 32'h417);
    gcc_enc_model_inst.step(1'b1, 4, 0);
    rdc(GCC_CNT_OFS, '1, 32'h0);
    chk(evt_n - e0, 32'h1);
    gcc_enc_model_inst.step(1'b0, 1, 1);
    rdc(GCC_CNT_OFS, '1, 32'hffffffff);
    cfg(32'h0, 32'hfffffffd, 32'h41b);
    gcc_enc_model_inst.step(1'b0, 3, 1);
    rdc(GCC_CNT_OFS, '1, 32'h0);
    cfg(32'h7ffffffe, 32'h0, 32'h413);
    gcc_enc_model_inst.step(1'b1, 2, 1);
    rdc(GCC_CNT_OFS, '1, 32'h7ffffffe);
    chk(evt_n - e0, 32'h1);
    cfg(32'h80000001, 32'h0, 32'h413);
    gcc_enc_model_inst.step(1'b0, 2, 1);
    rdc(GCC_CNT_OFS, '1, 32'h80000001);
    // Interrupt keeps count, abort reloads, latch survives
    cfg(32'h0, 32'h0, 32'h413);
    gcc_enc_model_inst.step(1'b1, 3, 1);
    gcc_enc_model_inst.latch();
    rdc(GCC_LATCH_OFS, '1, 32'h3);
    wr(GCC_CTRL_OFS, 32'h402);
    gcc_enc_model_inst.step(1'b1, 1, 1);
    rdc(GCC_CNT_OFS, '1, 32'h3);
    wr(GCC_CTRL_OFS, 32'h403);
    rdc(GCC_CNT_OFS, '1, 32'h3);
    wr(GCC_CTRL_OFS, 32'h412);
    wr(GCC_CTRL_OFS, 32'h413);
    rdc(GCC_CNT_OFS, '1, 32'h0);
    rdc(GCC_LATCH_OFS, '1, 32'h3);
    // Hardware gate joins the software gate
    cfg(32'h7, 32'h0, 32'h33);
    rdc(GCC_STAT_OFS, 32'h4, 32'h0);
    gcc_enc_model_inst.gate(1'b1);
    rdc(GCC_STAT_OFS, 32'h4, 32'h4);
    rdc(GCC_CNT_OFS, '1, 32'h7);
    gcc_enc_model_inst.step(1'b1, 2, 1);
    gcc_enc_model_inst.gate(1'b0);
    gcc_enc_model_inst.gate(1'b1);
    rdc(GCC_CNT_OFS, '1, 32'h7);
    // Once with hardware gate: reopen only after a hardware rise
    cfg(32'h7, 32'h5, 32'h39);
    gcc_enc_model_inst.step(1'b0, 2, 1);
    wr(GCC_CTRL_OFS, 32'h38);
    wr(GCC_CTRL_OFS, 32'h39);
    rdc(GCC_STAT_OFS, 32'hc, 32'h8);
    gcc_enc_model_inst.gate(1'b0);
    gcc_enc_model_inst.gate(1'b1);
    rdc(GCC_STAT_OFS, 32'hc, 32'h4);
    gcc_enc_model_inst.step(1'b0, 2, 1);
    wr(GCC_CTRL_OFS, 32'h38);
    gcc_enc_model_inst.gate(1'b0);
    gcc_enc_model_inst.gate(1'b1);
    wr(GCC_CTRL_OFS, 32'h39);
    rdc(GCC_STAT_OFS, 32'hc, 32'h4);
    // Plain output ignores output control
    wr(GCC_CTRL_OFS, 32'h200);
    repeat (3) @(posedge clk_i);
    chk({31'h0, dout_o}, 32'h1);
    rdc(GCC_STAT_OFS, 32'h3, 32'h0);
    wr(GCC_CTRL_OFS, 32'h100);
    repeat (3) @(posedge clk_i);
    chk({31'h0, dout_o}, 32'h0);
    // Level compares, hysteresis of one is off
    wr(GCC_HYST_OFS, 32'h1);
    wr(GCC_CMPV_OFS, 32'h2);
    cfg(32'h0, 32'h0, 32'h153);
    gcc_enc_model_inst.step(1'b1, 2, 2);
    chk({31'h0, dout_o}, 32'h1);
    wr(GCC_STAT_OFS, 32'h1);
    rdc(GCC_STAT_OFS, 32'h1, 32'h1);
    gcc_enc_model_inst.step(1'b0, 1, 2);
    chk({31'h0, dout_o}, 32'h0);
    wr(GCC_STAT_OFS, 32'h1);
    rdc(GCC_STAT_OFS, 32'h1, 32'h0);
    wr(GCC_CTRL_OFS, 32'h193);
    repeat (3) @(posedge clk_i);
    chk({31'h0, dout_o}, 32'h1);
    // Hysteresis of three holds the result inside the band
    wr(GCC_HYST_OFS, 32'h3);
    cfg(32'h0, 32'h0, 32'h153);
    gcc_enc_model_inst.step(1'b1, 2, 2);
    gcc_enc_model_inst.step(1'b0, 1, 2);
    chk({31'h0, dout_o}, 32'h1);
    gcc_enc_model_inst.step(1'b0, 3, 2);
    chk({31'h0, dout_o}, 32'h0);
    // Pulse of one 2 ms step, no retrigger while held at value
    wr(GCC_PDUR_OFS, 32'h1);
    cfg(32'h0, 32'h0, 32'h1d3);
    h0 = hi_n;
    // Compare value set once the count sits below it, so no stale hit
    wr(GCC_CMPV_OFS, 32'h1);
    gcc_enc_model_inst.step(1'b1, 1, 0);
    rdc(GCC_STAT_OFS, 32'h3, 32'h3);
    wr(GCC_STAT_OFS, 32'h1);
    repeat (40) @(posedge clk_i);
    chk(hi_n - h0, 32'd20);
    rdc(GCC_STAT_OFS, 32'h3, 32'h1);
    wrap_up;
  end
endmodule

// [dv/gcc_enc_model.sv]
// Encoder, gate and latch pin model
module gcc_enc_model (
  input wire logic clk_i, // Clock
  output logic cnt_up_o, // Up pulse
  output logic cnt_dn_o, // Down pulse
  output logic hw_gate_o, // Gate level
  output logic latch_o // Latch level
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cnt_up_o = 1'b0;
    cnt_dn_o = 1'b0;
    hw_gate_o = 1'b0;
    latch_o = 1'b0;
  end
  // One-cycle pulses; gap gives prompt or slow pacing
  task automatic step(input bit up, input int n, input int gap);
    repeat (n) begin
      if (up) cnt_up_o <= 1'b1;
      else cnt_dn_o <= 1'b1;
      @(posedge clk_i);
      cnt_up_o <= 1'b0;
      cnt_dn_o <= 1'b0;
      repeat (gap + 1) @(posedge clk_i);
    end
  endtask
  // Held past the three-edge synchroniser
  task automatic gate(input bit v);
    hw_gate_o <= v;
    repeat (5) @(posedge clk_i);
  endtask
  task automatic latch;
    latch_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    latch_o <= 1'b0;
    repeat (5) @(posedge clk_i);
  endtask
endmodule

// [rtl/gcc_channel.sv]
// One counter channel: modes, gate, comparator, pulse, latch, APB slave
//
// How it works
// - Count-once backward: count down, reload and close gate past end+1.
// - After auto close, only a gate rising edge restarts from load.
// - Backward may pass upper limit; periodic forward may pass lower limit.
// - Periodic without direction uses the full numeric range as limits.
// - Periodic without direction reloads at either limit and flags event.
// - Periodic forward: positive pulse at end-1 reloads, continues, event.
// - Periodic backward: negative pulse at end+1 reloads, continues, event.
// - Without hardware gate the software gate alone starts and stops.
// - With hardware gate enabled, internal gate is software AND hardware.
// - Abort reopens from load value; interrupt continues from count.
// - Hardware rise restarts under abort; software rise continues when the hardware gate is used.
// - After auto close, reopen on hardware rise or software after it.
// - Compare value held and compared continuously, drives output, status.
// - Latch rising edge while counting captures count; kept across stops.
// - No-comparison mode: plain output, control bit ignored, status clear.
// - Greater/less mode asserts output while true; clear only when false.
// - Pulse mode fires on reaching value from main direction; zero is level.
// - Compare status clears only after pulse ends; output flag mirrors pin in compare modes.
// - Pulse lasts 2 to 510 ms in 2 ms steps, exact to a cycle.
// - Pulse not retriggered while active; new duration used next pulse.
// - Hysteresis 0..255, values 0 and 1 disable it.
// - Hysteresis freezes result until band is left; width taken per event.
module gcc_channel
  import gcc_pkg::*;
#(
  parameter bit HAS_HW_GATE = 1'b1,
  parameter int MS_CYC = gcc_pkg::GCC_MS_CYC
) (
  input wire logic clk_i, // 250 MHz system clock
  input wire logic arst_n_i, // Async reset, active low
  input wire logic psel_i, // APB select
  input wire logic penable_i, // APB enable
  input wire logic pwrite_i, // APB write
  input wire logic [7:0] paddr_i, // APB byte address
  input wire logic [31:0] pwdata_i, // APB write data
  output logic [31:0] prdata_o, // APB read data
  output logic pready_o, // APB ready
  output logic pslverr_o, // APB error on unmapped address
  input wire logic cnt_up_i, // Positive count pulse
  input wire logic cnt_dn_i, // Negative count pulse
  input wire logic hw_gate_i, // Hardware gate pin
  input wire logic latch_i, // Latch pin
  output logic dout_o, // Channel digital output
  output logic wrap_evt_o // Limit or end event pulse
);
  import gcc_pkg::*;

  typedef struct packed {
    logic [GCC_CTRL_W-1:0] ctrl;
    logic [31:0] cnt;
    logic [31:0] load;
    logic [31:0] endv;
    logic [31:0] cmpv;
    logic [31:0] latch;
    logic [31:0] prdata;
    logic [7:0] pdur;
    logic [7:0] hyst;
    logic [7:0] hyst_w;
    logic [31:0] ms_cnt;
    logic [9:0] pms;
    logic pact;
    logic hact;
    logic res;
    logic last_up;
    logic gate;
    logic auto_cl;
    logic hw_seen;
    logic swg_p;
    logic hw1;
    logic hw2;
    logic hw3;
    logic la1;
    logic la2;
    logic la3;
    logic cmp_st;
    logic do_st;
    logic evt;
  } gcc_state_t;

  gcc_state_t s_q;
  gcc_state_t s_d;

  // Absolute distance of two signed words, one bit wider to avoid overflow
  function automatic logic [32:0] gcc_dist(input logic [31:0] a,
                                           input logic [31:0] b);
    logic [32:0] d;
    d = {a[31], a} - {b[31], b};
    return d[32] ? 33'(-d) : d;
  endfunction

  // ********************
  // Decoded controls
  // ********************
  gcc_mode_t mode;
  gcc_dir_t dir;
  gcc_omode_t omode;
  logic abort_sel;
  logic hw_use;
  logic swg;
  assign mode = gcc_mode_t'(s_q.ctrl[GCC_C_MODE]);
  assign dir = gcc_dir_t'(s_q.ctrl[GCC_C_DIR +: 2]);
  assign omode = gcc_omode_t'(s_q.ctrl[GCC_C_OMODE +: 2]);
  assign abort_sel = s_q.ctrl[GCC_C_ABORT];
  assign hw_use = HAS_HW_GATE && s_q.ctrl[GCC_C_HWEN];
  assign swg = s_q.ctrl[GCC_C_SWG];

  // Bus decode; unmapped offsets answer with an error
  logic acc;
  logic mapped;
  assign acc = psel_i && penable_i;
  assign mapped = (paddr_i[1:0] == 2'b00) && (paddr_i <= GCC_STAT_OFS);
  assign pready_o = 1'b1;
  assign pslverr_o = acc && !mapped;
  assign prdata_o = s_q.prdata;
  assign dout_o = s_q.do_st;
  assign wrap_evt_o = s_q.evt;

  // ********************
  // Next state
  // ********************
  always_comb begin
    logic wr;
    logic sw_rise;
    logic sw_fall;
    logic hw_rise;
    logic hw_fall;
    logic open_ev;
    logic reload_ev;
    logic step_up;
    logic step_dn;
    logic wrap;
    logic close;
    logic raw;
    logic res_n;
    logic start;
    logic clr_req;
    logic [31:0] rd;
    logic [31:0] endm1;
    logic [31:0] endp1;
    wr = 1'b0;
    sw_rise = 1'b0;
    sw_fall = 1'b0;
    hw_rise = 1'b0;
    hw_fall = 1'b0;
    open_ev = 1'b0;
    reload_ev = 1'b0;
    step_up = 1'b0;
    step_dn = 1'b0;
    wrap = 1'b0;
    close = 1'b0;
    raw = 1'b0;
    res_n = 1'b0;
    start = 1'b0;
    clr_req = 1'b0;
    rd = 32'h00000000;
    endm1 = s_q.endv - 32'h00000001;
    endp1 = s_q.endv + 32'h00000001;
    s_d = s_q;
    s_d.evt = 1'b0;

    // Two-stage synchronisers, third stage for edge detection
    s_d.hw1 = hw_gate_i;
    s_d.hw2 = s_q.hw1;
    s_d.hw3 = s_q.hw2;
    s_d.la1 = latch_i;
    s_d.la2 = s_q.la1;
    s_d.la3 = s_q.la2;
    hw_rise = s_q.hw2 && !s_q.hw3;
    hw_fall = !s_q.hw2 && s_q.hw3;

    // Register writes in the access cycle, read data capture in the setup cycle
    wr = acc && pwrite_i && mapped;
    if (wr) begin
      unique case (paddr_i)
        GCC_CTRL_OFS: s_d.ctrl = pwdata_i[GCC_CTRL_W-1:0];
        GCC_LOAD_OFS: s_d.load = pwdata_i;
        GCC_END_OFS: s_d.endv = pwdata_i;
        GCC_CMPV_OFS: s_d.cmpv = pwdata_i;
        GCC_PDUR_OFS: s_d.pdur = pwdata_i[7:0];
        GCC_HYST_OFS: s_d.hyst = pwdata_i[7:0];
        GCC_STAT_OFS: clr_req = pwdata_i[GCC_S_CMP];
        default: ;
      endcase
    end
    if (psel_i && !penable_i) begin
      unique case (paddr_i)
        GCC_CTRL_OFS: rd = {21'h000000, s_q.ctrl};
        GCC_LOAD_OFS: rd = s_q.load;
        GCC_END_OFS: rd = s_q.endv;
        GCC_CMPV_OFS: rd = s_q.cmpv;
        GCC_PDUR_OFS: rd = {24'h000000, s_q.pdur};
        GCC_HYST_OFS: rd = {24'h000000, s_q.hyst};
        GCC_CNT_OFS: rd = s_q.cnt;
        GCC_LATCH_OFS: rd = s_q.latch;
        // Output state reads clear while the pin is a plain output
        GCC_STAT_OFS: rd = {28'h0000000, s_q.auto_cl, s_q.gate,
                            s_q.do_st && omode != GCC_ONONE,
                            s_q.cmp_st};
        default: rd = 32'h00000000;
      endcase
      s_d.prdata = rd;
    end

    // ********************
    // Gate
    // ********************
    // Software gate edges come from the control bit as last seen
    s_d.swg_p = swg;
    sw_rise = swg && !s_q.swg_p;
    sw_fall = !swg && s_q.swg_p;
    if (!hw_use) begin
      open_ev = sw_rise && !s_q.gate;
      reload_ev = open_ev && abort_sel;
      if (sw_fall) begin
        s_d.gate = 1'b0;
      end
    end else begin
      // Auto closed: software rise counts only after a hardware rise
      if (s_q.auto_cl && hw_rise && !swg) begin
        s_d.hw_seen = 1'b1;
      end
      if (hw_rise && swg && !s_q.gate) begin
        open_ev = 1'b1;
        reload_ev = abort_sel;
      end else if (sw_rise && s_q.hw2 && !s_q.gate &&
                   (!s_q.auto_cl || s_q.hw_seen)) begin
        open_ev = 1'b1;
      end
      if (sw_fall || hw_fall) begin
        s_d.gate = 1'b0;
      end
    end
    if (open_ev) begin
      s_d.gate = 1'b1;
      s_d.auto_cl = 1'b0;
      s_d.hw_seen = 1'b0;
    end

    // ********************
    // Counting
    // ********************
    step_up = s_q.gate && cnt_up_i && !cnt_dn_i;
    step_dn = s_q.gate && cnt_dn_i && !cnt_up_i;
    if (reload_ev) begin
      s_d.cnt = s_q.load;
    end else if (step_up || step_dn) begin
      s_d.last_up = step_up;
      // Plain step wraps past the far limit, allowed where ends are fixed
      s_d.cnt = step_up ? s_q.cnt + 32'h00000001
                        : s_q.cnt - 32'h00000001;
      unique case (dir)
        GCC_DFWD: wrap = step_up && s_q.cnt == endm1;
        GCC_DBWD: wrap = step_dn && s_q.cnt == endp1;
        default: wrap = (step_up && s_q.cnt == GCC_MAX) ||
                        (step_dn && s_q.cnt == GCC_MIN);
      endcase
      if (wrap) begin
        // Once without direction jumps to the other limit instead
        if (!(mode == GCC_ONCE && (dir == GCC_DNONE || dir == GCC_DRSV))) begin
          s_d.cnt = s_q.load;
        end
        s_d.evt = s_q.ctrl[GCC_C_EVEN];
        close = (mode == GCC_ONCE);
      end
    end
    if (close) begin
      s_d.gate = 1'b0;
      s_d.auto_cl = 1'b1;
      s_d.hw_seen = 1'b0;
    end

    // Latch captures only while counting; only reset clears it
    if (s_q.la2 && !s_q.la3 && s_q.gate) begin
      s_d.latch = s_q.cnt;
    end

    // ********************
    // Comparator and hysteresis
    // ********************
    unique case (omode)
      GCC_OGE: raw = $signed(s_q.cnt) >= $signed(s_q.cmpv);
      GCC_OLE: raw = $signed(s_q.cnt) <= $signed(s_q.cmpv);
      GCC_OPULSE: raw = (s_q.cnt == s_q.cmpv) &&
                        (dir == GCC_DNONE || dir == GCC_DRSV ||
                         (dir == GCC_DFWD) == s_q.last_up);
      default: raw = 1'b0;
    endcase
    res_n = raw;
    if (s_q.hact) begin
      // Frozen until the counter leaves the band taken at activation
      res_n = s_q.res;
      if (gcc_dist(s_q.cnt, s_q.cmpv) > {25'h0000000, s_q.hyst_w}) begin
        s_d.hact = 1'b0;
        res_n = raw;
      end
    end else if (raw && !s_q.res && s_q.hyst > GCC_HYST_MIN) begin
      s_d.hact = 1'b1;
      s_d.hyst_w = s_q.hyst;
    end
    s_d.res = res_n;

    // ********************
    // Pulse timer
    // ********************
    // Ms divider restarts with each pulse, so error stays under a cycle
    start = omode == GCC_OPULSE && res_n && !s_q.res && !s_q.pact &&
            s_q.pdur != 8'h00;
    if (start) begin
      s_d.pact = 1'b1;
      s_d.ms_cnt = 32'h00000000;
      s_d.pms = 10'({2'b00, s_q.pdur} * GCC_PDUR_STEP_MS);
    end else if (s_q.pact) begin
      if (s_q.ms_cnt == 32'(MS_CYC - 1)) begin
        s_d.ms_cnt = 32'h00000000;
        s_d.pms = s_q.pms - 10'h001;
        if (s_q.pms == 10'h001) begin
          s_d.pact = 1'b0;
        end
      end else begin
        s_d.ms_cnt = s_q.ms_cnt + 32'h00000001;
      end
    end
    if (omode != GCC_OPULSE) begin
      s_d.pact = 1'b0;
    end

    // ********************
    // Output and compare status
    // ********************
    unique case (omode)
      GCC_ONONE: begin
        s_d.do_st = s_q.ctrl[GCC_C_DSW];
        s_d.cmp_st = 1'b0;
      end
      GCC_OGE, GCC_OLE: begin
        s_d.do_st = s_q.ctrl[GCC_C_DO] && res_n;
        // Set wins over a clear arriving in the same cycle
        if (clr_req && !res_n) begin
          s_d.cmp_st = 1'b0;
        end
        if (res_n) begin
          s_d.cmp_st = 1'b1;
        end
      end
      default: begin
        s_d.do_st = s_q.ctrl[GCC_C_DO] &&
                    (s_q.pdur == 8'h00 ? res_n : s_d.pact);
        if (clr_req && !s_d.pact) begin
          s_d.cmp_st = 1'b0;
        end
        if (start || (s_q.pdur == 8'h00 && res_n)) begin
          s_d.cmp_st = 1'b1;
        end
      end
    endcase
  end

  // ********************
  // State register
  // ********************
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_q <= '0;
      s_q.ctrl <= GCC_CTRL_RST;
    end else begin
      s_q <= s_d;
    end
  end
endmodule
